// ==== crosspoint_params.svh ====
`ifndef CROSSPOINT_PARAMS_SVH
`define CROSSPOINT_PARAMS_SVH

// Setup memory geometry
`define SETUP_FIRST       7'h01
`define SETUP_LAST        7'h64
`define SETUP_TOP_MOVED   7'h63
`define UNIT_MAX          3'h4
`define COLS_PER_UNIT     16'h0048
`define SETUP_STRIDE      16'h0168
`define SETUP_LAST_BYTE   16'h0167
`define MEM_WORDS         36000

// Block layout, in raw byte positions
`define IDX_SETUP_HI      7'h00
`define IDX_SETUP_LO      7'h01
`define IDX_UNIT          7'h02
`define IDX_FIRST_COL     7'h03
`define IDX_CHECKSUM      7'h4B

// Column codes and key numbers
`define ROWS_NONE         8'h00
`define KEY_FIRST         7'h01
`define KEY_LAST          7'h29
`define KEY_ENTER         7'h25
`define KEY_RESET         7'h26
`define KEY_OPEN          7'h28
`define KEY_CLOSE         7'h29

// Output path
`define OUT_WIDTH         9
`define OUT_DEPTH         32

`endif

// ==== crosspoint_pkg.sv ====
package crosspoint_pkg;

  typedef enum logic [1:0] {
    OP_READOUT,
    OP_HIT_KEY,
    OP_INSERT,
    OP_WRITE
  } op_e;

  typedef enum logic [1:0] {
    condensed_hex_format,
    condensed_hex_format_per_unit,
    raw_binary_format,
    raw_binary_format_per_unit
  } fmt_e;

  // One command from the bus command parser
  typedef struct packed {
    op_e        op;
    fmt_e       fmt;
    logic [6:0] setup;
    logic [2:0] unit;
    logic [6:0] column;
    logic [7:0] rows;
    logic [6:0] key;
  } cmd_s;

  // One byte of readout with its end-of-talk mark
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } out_s;

endpackage : crosspoint_pkg

// ==== crosspoint_setup_command_port.sv ====
`include "crosspoint_params.svh"

module out_fifo #(
  parameter int WIDTH = `OUT_WIDTH,
  parameter int DEPTH = `OUT_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push, pop;

  // Honest full and empty from the fill count
  always_comb begin
    in_ready    = (count_reg != AW'(0) + (AW+1)'(DEPTH)) && clk_en;
    out_valid   = (count_reg != '0);
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready && clk_en;
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    out_data    = store[rd_ptr_reg];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end
endmodule : out_fifo

module crosspoint_setup_command_port (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire crosspoint_pkg::cmd_s cmd,
  input  wire logic [2:0]           slave_count,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [7:0]                out_data,
  output logic                      out_last,
  output logic                      key_valid,
  output logic [6:0]                key_code,
  output logic                      display_blank,
  output logic                      cmd_error
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_MOVE,
    ST_CLEAR
  } state_e;

  // Setup memory: 100 setups of 5 units of 72 column bytes
  logic [7:0] setup_mem [`MEM_WORDS];

  state_e      state_reg, state_next;
  logic [6:0]  setup_reg, setup_next;
  logic [2:0]  unit_reg, unit_next, last_unit_reg, last_unit_next;
  logic [6:0]  idx_reg, idx_next;
  logic        nib_reg, nib_next, hex_reg, hex_next;
  logic [7:0]  sum_reg, sum_next;
  logic [15:0] ptr_reg, ptr_next;
  logic        key_valid_next, blank_next, error_next;
  logic [6:0]  key_code_next;

  logic        mem_we;
  logic [15:0] mem_waddr, rd_addr;
  logic [7:0]  mem_wdata, rd_data, raw_byte, tx_char;
  logic [2:0]  present_max;
  logic        push, byte_done;
  crosspoint_pkg::out_s push_word, pop_word;
  logic        fifo_ready;

  // Byte address of the first column byte of a setup
  function automatic logic [15:0] setup_base(input logic [6:0] s);
    logic [31:0] prod;
    prod = 32'({9'h000, s} - 16'h0001) * 32'(`SETUP_STRIDE);
    return prod[15:0];
  endfunction : setup_base

  // Nibble to printable upper-case hex digit
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hex_char

  function automatic logic setup_ok(input logic [6:0] s);
    return (s >= `SETUP_FIRST) && (s <= `SETUP_LAST);
  endfunction : setup_ok

  // Slave count above four is clipped to the largest system
  always_comb begin
    present_max = (slave_count > `UNIT_MAX) ? `UNIT_MAX : slave_count;
    rd_addr     = setup_base(setup_reg) +
                  16'({13'h0000, unit_reg} * `COLS_PER_UNIT) +
                  {9'h000, idx_reg - `IDX_FIRST_COL};
    rd_data     = setup_mem[rd_addr];
  end

  // Raw block byte, then its text form for the hex formats
  always_comb begin
    if (idx_reg == `IDX_SETUP_HI) begin
      raw_byte = 8'h00;
    end else if (idx_reg == `IDX_SETUP_LO) begin
      raw_byte = {1'b0, setup_reg};
    end else if (idx_reg == `IDX_UNIT) begin
      raw_byte = {5'h00, unit_reg};
    end else if (idx_reg == `IDX_CHECKSUM) begin
      raw_byte = sum_reg;
    end else begin
      raw_byte = rd_data;
    end
    // Hex sends high nibble first; binary sends the byte untouched
    if (hex_reg) begin
      tx_char = hex_char(nib_reg ? raw_byte[3:0] : raw_byte[7:4]);
    end else begin
      tx_char = raw_byte;
    end
  end

  // Command decode, readout sequencing and insert shifting
  always_comb begin
    state_next     = state_reg;
    setup_next     = setup_reg;
    unit_next      = unit_reg;
    last_unit_next = last_unit_reg;
    idx_next       = idx_reg;
    nib_next       = nib_reg;
    hex_next       = hex_reg;
    sum_next       = sum_reg;
    ptr_next       = ptr_reg;
    key_valid_next = 1'b0;
    key_code_next  = key_code;
    blank_next     = display_blank;
    error_next     = 1'b0;
    mem_we         = 1'b0;
    mem_waddr      = ptr_reg;
    mem_wdata      = `ROWS_NONE;
    push           = 1'b0;
    byte_done      = 1'b0;
    push_word      = '{last: 1'b0, data: tx_char};
    cmd_ready      = (state_reg == ST_IDLE);
    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid) begin
          case (cmd.op)
            crosspoint_pkg::OP_HIT_KEY: begin
              // Lockout gates only real keys, never this path
              if (cmd.key >= `KEY_FIRST && cmd.key <= `KEY_LAST) begin
                key_valid_next = 1'b1;
                key_code_next  = cmd.key;
              end else begin
                error_next = 1'b1;
              end
            end
            crosspoint_pkg::OP_INSERT: begin
              if (setup_ok(cmd.setup)) begin
                setup_next = cmd.setup;
                blank_next = 1'b1;
                if (cmd.setup == `SETUP_LAST) begin
                  ptr_next   = setup_base(`SETUP_LAST);
                  state_next = ST_CLEAR;
                end else begin
                  ptr_next   = setup_base(`SETUP_TOP_MOVED) +
                               `SETUP_LAST_BYTE;
                  state_next = ST_MOVE;
                end
              end else begin
                error_next = 1'b1;
              end
            end
            crosspoint_pkg::OP_WRITE: begin
              if (setup_ok(cmd.setup) && cmd.unit <= present_max &&
                  {9'h000, cmd.column} < `COLS_PER_UNIT) begin
                mem_we    = 1'b1;
                mem_waddr = setup_base(cmd.setup) +
                            16'({13'h0000, cmd.unit} * `COLS_PER_UNIT) +
                            {9'h000, cmd.column};
                mem_wdata = cmd.rows;
              end else begin
                error_next = 1'b1;
              end
            end
            default: begin
              if (setup_ok(cmd.setup) &&
                  (cmd.unit <= present_max ||
                   cmd.fmt == crosspoint_pkg::condensed_hex_format ||
                   cmd.fmt == crosspoint_pkg::raw_binary_format)) begin
                setup_next = cmd.setup;
                idx_next   = `IDX_SETUP_HI;
                nib_next   = 1'b0;
                sum_next   = 8'h00;
                hex_next   =
                  (cmd.fmt == crosspoint_pkg::condensed_hex_format) ||
                  (cmd.fmt == crosspoint_pkg::condensed_hex_format_per_unit);
                // Whole-system formats walk master then slaves
                if (cmd.fmt == crosspoint_pkg::condensed_hex_format ||
                    cmd.fmt == crosspoint_pkg::raw_binary_format) begin
                  unit_next      = 3'h0;
                  last_unit_next = present_max;
                end else begin
                  unit_next      = cmd.unit;
                  last_unit_next = cmd.unit;
                end
                state_next = ST_READ;
              end else begin
                error_next = 1'b1;
              end
            end
          endcase
        end
      end
      ST_READ: begin
        // Stalls here whenever the output buffer is full
        push      = 1'b1;
        byte_done = !hex_reg || nib_reg;
        push_word.last = byte_done && (idx_reg == `IDX_CHECKSUM) &&
                         (unit_reg == last_unit_reg);
        if (fifo_ready) begin
          nib_next = hex_reg && !nib_reg;
          if (byte_done) begin
            sum_next = sum_reg + raw_byte;
            if (idx_reg != `IDX_CHECKSUM) begin
              idx_next = idx_reg + 7'h01;
            end else if (unit_reg != last_unit_reg) begin
              // Next unit follows directly, no separator
              unit_next = unit_reg + 3'h1;
              idx_next  = `IDX_SETUP_HI;
              sum_next  = 8'h00;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      end
      ST_MOVE: begin
        // Top byte first, so no setup is overwritten before it moves
        mem_we    = 1'b1;
        mem_waddr = ptr_reg + `SETUP_STRIDE;
        mem_wdata = setup_mem[ptr_reg];
        if (ptr_reg == setup_base(setup_reg)) begin
          state_next = ST_CLEAR;
        end else begin
          ptr_next = ptr_reg - 16'h0001;
        end
      end
      ST_CLEAR: begin
        mem_we    = 1'b1;
        mem_waddr = ptr_reg;
        mem_wdata = `ROWS_NONE;
        if (ptr_reg == setup_base(setup_reg) + `SETUP_LAST_BYTE) begin
          blank_next = 1'b0;
          state_next = ST_IDLE;
        end else begin
          ptr_next = ptr_reg + 16'h0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!clk_en) begin
      mem_we    = 1'b0;
      push      = 1'b0;
      cmd_ready = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      setup_reg     <= `SETUP_FIRST;
      unit_reg      <= 3'h0;
      last_unit_reg <= 3'h0;
      idx_reg       <= `IDX_SETUP_HI;
      nib_reg       <= 1'b0;
      hex_reg       <= 1'b0;
      sum_reg       <= 8'h00;
      ptr_reg       <= 16'h0000;
      key_valid     <= 1'b0;
      key_code      <= 7'h00;
      display_blank <= 1'b0;
      cmd_error     <= 1'b0;
    end else if (clk_en) begin
      state_reg     <= state_next;
      setup_reg     <= setup_next;
      unit_reg      <= unit_next;
      last_unit_reg <= last_unit_next;
      idx_reg       <= idx_next;
      nib_reg       <= nib_next;
      hex_reg       <= hex_next;
      sum_reg       <= sum_next;
      ptr_reg       <= ptr_next;
      key_valid     <= key_valid_next;
      key_code      <= key_code_next;
      display_blank <= blank_next;
      cmd_error     <= error_next;
    end
  end

  // Setup memory write port; contents survive reset
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      setup_mem[mem_waddr] <= mem_wdata;
    end
  end

  // Buffer decouples readout from the bus talker
  out_fifo #(
    .WIDTH (`OUT_WIDTH),
    .DEPTH (`OUT_DEPTH)
  ) u_out_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (pop_word)
  );

  always_comb begin
    out_data = pop_word.data;
    out_last = pop_word.last;
  end
endmodule : crosspoint_setup_command_port

// ==== port_asserts.sv ====
module port_asserts (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire crosspoint_pkg::cmd_s cmd,
  input wire logic [2:0]           slave_count,
  input wire logic                 out_valid,
  input wire logic                 out_ready,
  input wire logic [7:0]           out_data,
  input wire logic                 out_last,
  input wire logic                 key_valid,
  input wire logic [6:0]           key_code,
  input wire logic                 display_blank,
  input wire logic                 cmd_error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic        tk, is_key, is_ins, key_ok, ins_ok, hex_reg, hex_next;
  logic [6:0]  n_reg, n_next;
  logic [15:0] len_reg, len_next;
  int          want;
  // Decoded takes of the command port
  assign tk = cmd_valid && cmd_ready && clk_en;
  assign is_key = tk && cmd.op == crosspoint_pkg::OP_HIT_KEY;
  assign is_ins = tk && cmd.op == crosspoint_pkg::OP_INSERT;
  assign key_ok = cmd.key >= 7'h01 && cmd.key <= 7'h29;
  assign ins_ok = cmd.setup >= 7'h01 && cmd.setup <= 7'h64;
  assign want = (101 - int'(n_reg)) * 360;
  // Insert location, talk kind and blank length
  always_comb begin
    n_next = n_reg;
    hex_next = hex_reg;
    len_next = display_blank ? len_reg + 16'h0001 : 16'h0000;
    if (is_ins)
      n_next = cmd.setup;
    if (tk && cmd.op == crosspoint_pkg::OP_READOUT)
      hex_next = !cmd.fmt[1];
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      n_reg   <= 7'h00;
      hex_reg <= 1'b0;
      len_reg <= 16'h0000;
    end else begin
      n_reg   <= n_next;
      hex_reg <= hex_next;
      len_reg <= len_next;
    end
  end
  a_key_press: assert property (
    is_key && key_ok |=> key_valid && key_code == $past(cmd.key))
    else $error("key press not reported");
  a_key_refused: assert property (
    is_key && !key_ok |=> cmd_error && !key_valid)
    else $error("bad key number accepted");
  a_blank_start: assert property (
    is_ins && ins_ok |=> display_blank)
    else $error("display not blanked by insert");
  a_ins_refused: assert property (
    is_ins && !ins_ok |=> cmd_error && !display_blank)
    else $error("bad insert location accepted");
  a_blank_len: assert property (
    $fell(display_blank) |-> len_reg inside {[want:want + 1]})
    else $error("insert took the wrong time");
  a_blank_busy: assert property (
    display_blank |-> !cmd_ready)
    else $error("command taken during insert");
  a_stream_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last)) else $error("stalled byte changed");
  a_hex_chars: assert property (
    out_valid && hex_reg |-> out_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("hex talk byte not a hex digit");
  c_key: cover property (key_valid);
  c_insert: cover property ($fell(display_blank));
  c_last: cover property (out_valid && out_ready && out_last);
endmodule : port_asserts

// ==== host_reader.sv ====
module host_reader (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  input  wire logic       slow,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got[$];
  int         wait_n;
  // Slow mode holds off each talk 40 cycles, so the FIFO fills and refuses
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
      wait_n    <= 0;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back({out_last, out_data});
        if (out_last)
          wait_n <= 0;
      end else if (out_valid)
        wait_n <= wait_n + 1;
      out_ready <= !slow || wait_n >= 40;
    end
  end
endmodule : host_reader

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk_sys, reset_n, clk_en, cmd_valid, cmd_ready;
  crosspoint_pkg::cmd_s cmd;
  logic [2:0]           slave_count;
  logic                 out_valid, out_ready, out_last, key_valid;
  logic [7:0]           out_data;
  logic [6:0]           key_code;
  logic                 display_blank, cmd_error, slow;
  logic [7:0]           img[72];
  int                   n_mismatch, checks_done;

  crosspoint_setup_command_port u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .slave_count(slave_count), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .key_valid(key_valid),
    .key_code(key_code), .display_blank(display_blank),
    .cmd_error(cmd_error));
  host_reader u_host (.clk_sys(clk_sys), .reset_n(reset_n),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .slow(slow), .out_ready(out_ready));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Hold the command until a rising edge sees it taken
  task automatic send(input logic [1:0] op, input logic [1:0] fmt,
                      input logic [6:0] s, input logic [2:0] u,
                      input logic [6:0] col, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd <= '{crosspoint_pkg::op_e'(op), crosspoint_pkg::fmt_e'(fmt),
             s, u, col, v, v[6:0]};
    cmd_valid <= 1'b1;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1 && n++ < 9000);
    // A port that never frees up is a failure, not a silent send
    if (n > 9000) begin
      n_mismatch++;
      $display("ERROR %0t: command never taken", $time);
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask : send

  // Every key number, each as its own terminated command
  task automatic t_keys;
    for (int k = 1; k <= 41; k++) begin
      send(2'h1, 2'h0, 7'h01, 3'h0, 7'h00, 8'(k));
      cyc(1);
      chk(key_valid, 1'b1);
      chk(key_code, 7'(k));
      cyc(1);
      chk(key_valid, 1'b0);
    end
  endtask : t_keys

  task automatic refuse(input logic [1:0] op, input logic [1:0] fmt,
                        input logic [6:0] s, input logic [2:0] u,
                        input logic [6:0] col, input logic [7:0] v);
    send(op, fmt, s, u, col, v);
    cyc(1);
    chk({cmd_error, key_valid, display_blank}, 3'h4);
    chk(out_valid, 1'b0);
  endtask : refuse

  // Out-of-range key, location, unit and column are all turned away
  task automatic t_refuse;
    refuse(2'h1, 2'h0, 7'h01, 3'h0, 7'h00, 8'h00);
    refuse(2'h1, 2'h0, 7'h01, 3'h0, 7'h00, 8'h2A);
    refuse(2'h2, 2'h0, 7'h00, 3'h0, 7'h00, 8'h00);
    refuse(2'h2, 2'h0, 7'h65, 3'h0, 7'h00, 8'h00);
    refuse(2'h0, 2'h1, 7'h01, 3'h1, 7'h00, 8'h00);
    refuse(2'h3, 2'h0, 7'h01, 3'h0, 7'h48, 8'h01);
  endtask : t_refuse

  // Insert, timing the blank span against the shift length
  task automatic t_ins(input logic [6:0] n);
    int c, w;
    c = 0;
    w = (101 - int'(n)) * 360;
    send(2'h2, 2'h0, n, 3'h0, 7'h00, 8'h00);
    cyc(1);
    chk(cmd_ready, 1'b0);
    while (display_blank === 1'b1 && c < 40000) begin
      c++;
      cyc(1);
    end
    chk(c >= w && c <= w + 1, 1'b1);
  endtask : t_ins

  function automatic logic [7:0] hexc(input logic [3:0] d);
    return d < 4'hA ? 8'h30 + d : 8'h37 + d;
  endfunction : hexc

  // Read one setup and compare the whole byte stream, units 0..nu
  task automatic t_read(input logic [1:0] fmt, input logic [6:0] s,
                        input logic s_slow, input logic [2:0] nu);
    logic [7:0] raw[76];
    logic [8:0] exp[$];
    int n, c;
    c = 0;
    slow = s_slow;
    u_host.got.delete();
    @(posedge clk_sys);
    slave_count <= nu;
    // Only the master block carries the image; slave blocks are blank
    for (int u = 0; u <= int'(nu); u++) begin
      raw[0] = 8'h00;
      raw[1] = {1'b0, s};
      raw[2] = 8'(u);
      raw[75] = raw[1] + raw[2];
      for (int i = 0; i < 72; i++) begin
        raw[i + 3] = (u == 0) ? img[i] : 8'h00;
        raw[75] += raw[i + 3];
      end
      for (int i = 0; i < 76; i++)
        if (fmt[1])
          exp.push_back({1'b0, raw[i]});
        else begin
          exp.push_back({1'b0, hexc(raw[i][7:4])});
          exp.push_back({1'b0, hexc(raw[i][3:0])});
        end
    end
    n = exp.size();
    exp[n - 1] = exp[n - 1] | 9'h100;
    send(2'h0, fmt, s, 3'h0, 7'h00, 8'h00);
    while (u_host.got.size() < n && c < 3000) begin
      cyc(1);
      c++;
    end
    cyc(10);
    chk(16'(u_host.got.size()), 16'(exp.size()));
    foreach (exp[i])
      chk(u_host.got[i], exp[i]);
    // Same loop covers raw bytes and trailing checksum
  endtask : t_read

  task automatic results;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Main sequence; setup 99 is built, then shifted into 100
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slave_count = 3'h0;
    slow = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    foreach (img[i]) img[i] = 8'h00;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_keys;
    t_refuse;
    t_ins(7'h63);
    img[0] = 8'h01;
    img[35] = 8'h5A;
    img[71] = 8'h80;
    foreach (img[i]) send(2'h3, 2'h0, 7'h63, 3'h0, 7'(i), img[i]);
    t_ins(7'h63);
    t_read(2'h3, 7'h64, 1'b1, 3'h0);
    t_read(2'h0, 7'h64, 1'b0, 3'h4);
    foreach (img[i]) img[i] = 8'h00;
    t_read(2'h1, 7'h63, 1'b0, 3'h0);
    t_read(2'h2, 7'h63, 1'b1, 3'h2);
    results;
  end

  // Run needs under 10000 cycles; 300 us leaves a wide margin
  initial begin
    #300us;
    n_mismatch++;
    results;
  end
endmodule : tb_top

bind crosspoint_setup_command_port port_asserts u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .slave_count(slave_count),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_last(out_last), .key_valid(key_valid), .key_code(key_code),
  .display_blank(display_blank), .cmd_error(cmd_error));
